// ### rtl/pndcmd_pkg.sv
// package for the pending-request and event-enable command block
// assumes decoded command fields in and parallel response fields out at the block edge
package pndcmd_pkg;
  // command and response type codes
  localparam logic [7:0] CMD_EVT_ENABLE = 8'h55;
  localparam logic [7:0] CMD_QUERY_PEND = 8'h56;
  localparam logic [7:0] CMD_SEND_REPLY = 8'h57;
  localparam logic [7:0] RSP_EVT_ENABLE = 8'hD5;
  localparam logic [7:0] RSP_QUERY_PEND = 8'hD6;
  localparam logic [7:0] RSP_SEND_REPLY = 8'hD7;
  localparam logic [7:0] RSP_UNKNOWN = 8'hFF;
  // notification type codes gated by the enable bits
  localparam logic [7:0] EVT_MEDIUM = 8'h70;
  localparam logic [7:0] EVT_PLDM = 8'h71;
  localparam logic [7:0] EVT_SPDM = 8'h72;
  // enable bitmap field positions
  localparam int EN_MEDIUM_BIT = 0;
  localparam int EN_PLDM_BIT = 1;
  localparam int EN_SPDM_BIT = 2;
  localparam int EN_WIDTH = 16;
  localparam logic [2:0] EN_RESET = 3'h0;
  // generic response and reason codes only
  localparam logic [15:0] RESP_OK = 16'h0000;
  localparam logic [15:0] RSP_FAIL = 16'h0001;
  localparam logic [15:0] REASON_NONE = 16'h0000;
  localparam logic [15:0] REASON_UNKNOWN = 16'h0003;
  // reply flags byte
  localparam int FLAG_PEND_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // queue defaults
  localparam int QUEUE_DEPTH = 4;
  localparam int MSG_WIDTH = 32;
  localparam logic [7:0] OWNER_ID_RESET = 8'h00;
endpackage

// ### rtl/pndcmd_queue.sv
// queue of device-originated requests awaiting delivery
// assumes pushes from local logic and pops from the command engine
`timescale 1ns/10ps
module pndcmd_queue #(
  parameter int WIDTH = pndcmd_pkg::MSG_WIDTH,
  parameter int DEPTH = pndcmd_pkg::QUEUE_DEPTH
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic empty_out,
  output logic full_out,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("queue depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // request storage
  logic [AW-1:0] rd_ptr; // oldest entry
  logic [AW-1:0] wr_ptr; // next free slot
  logic [AW:0] count; // entries held
  wire do_push = push_in && (count != (AW+1)'(DEPTH));
  wire do_pop = pop_in && (count != '0);

  // pointers and count; a push into a full queue is dropped
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // storage write, no reset needed for data
  always_ff @(posedge mclk_in) begin
    if (do_push)
      mem[wr_ptr] <= push_data_in;
  end

  assign head_out = mem[rd_ptr];
  assign empty_out = (count == '0);
  assign full_out = (count == (AW+1)'(DEPTH));
  assign count_out = count;
endmodule

// ### rtl/pndcmd_core.sv
// command interpreter for pending-request query, reply and event enable
// assumes a decoded command arrives as one strobe with its fields; header,
// checksum and padding are built by the packet framer outside
//
// Contract
// - recognise query 0x56, answer with 0xD6
// - one request at most per query answer
// - device picks delivery order of queued requests
// - query command implemented for originated requests
// - empty queue: query succeeds, no request content
// - codes at 16-19, request from byte 20
// - request fields present only when one pending
// - 0xD7 flags bit 0 shows more pending
// - flag bits 7 to 1 read zero
// - only generic reason codes used
// - accept 0x55 event-enable command
// - store owner identifier, stamp every notification
// - bit 0 gates medium-change notification 0x70
// - bit 1 gates pending-request notification 0x71
// - bit 2 gates pending-secure-request notification 0x72
// - event-enable answered with 0xD5
`timescale 1ns/10ps
module pndcmd_core #(
  parameter int MSG_W = pndcmd_pkg::MSG_WIDTH,
  parameter int DEPTH = pndcmd_pkg::QUEUE_DEPTH
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // decoded command from the management_controller
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_type_in,
  input wire logic cmd_error_in,
  input wire logic [31:0] cmd_word16_in,
  input wire logic [7:0] cmd_owner_in,
  // locally originated requests
  input wire logic req_push_in,
  input wire logic [MSG_W-1:0] req_data_in,
  output logic req_full_out,
  // local events wanting notification
  input wire logic medium_event_in,
  input wire logic spdm_event_in,
  // response
  output logic rsp_valid_out,
  output logic [7:0] rsp_type_out,
  output logic [15:0] rsp_code_out,
  output logic [15:0] rsp_reason_out,
  output logic rsp_has_msg_out,
  output logic [MSG_W-1:0] rsp_msg_out,
  output logic [7:0] rsp_flags_out,
  // notification
  output logic evt_valid_out,
  output logic [7:0] evt_type_out,
  output logic [7:0] evt_owner_out,
  // status
  output logic [2:0] evt_enable_out,
  output logic pending_out,
  output logic [31:0] reply_word_out
);
  initial begin
    if (MSG_W < 8)
      $error("message width must be at least 8");
  end

  // queue interface
  logic q_pop; // pop on delivery
  logic [MSG_W-1:0] q_head; // next request to hand out
  logic q_empty; // nothing pending
  logic q_full; // no room
  logic [$clog2(DEPTH):0] q_count; // entries held

  // oldest-first order chosen by the device
  pndcmd_queue #(.WIDTH(MSG_W), .DEPTH(DEPTH)) u_queue (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(req_push_in),
    .push_data_in(req_data_in),
    .pop_in(q_pop),
    .head_out(q_head),
    .empty_out(q_empty),
    .full_out(q_full),
    .count_out(q_count)
  );

  // command decode
  wire is_query = cmd_valid_in && !cmd_error_in &&
    (cmd_type_in == pndcmd_pkg::CMD_QUERY_PEND);
  wire is_reply = cmd_valid_in && !cmd_error_in &&
    (cmd_type_in == pndcmd_pkg::CMD_SEND_REPLY);
  wire is_enable = cmd_valid_in && !cmd_error_in &&
    (cmd_type_in == pndcmd_pkg::CMD_EVT_ENABLE);
  wire is_other = cmd_valid_in && !is_query && !is_reply && !is_enable;
  // a pending request is present after this query's pop
  wire more_after_pop = (q_count > ($clog2(DEPTH)+1)'(1));
  // one request per query, only when present
  assign q_pop = is_query && !q_empty;
  // low half of bytes 16-19 is the enable bitmap; bits above 2 reserved
  wire [pndcmd_pkg::EN_WIDTH-1:0] en_map = cmd_word16_in[15:0];

  // notification request, gated by enables
  logic pldm_arrived; // first request entering empty queue
  assign pldm_arrived = req_push_in && q_empty;
  wire want_medium = medium_event_in &&
    evt_enable_out[pndcmd_pkg::EN_MEDIUM_BIT];
  wire want_pldm = pldm_arrived &&
    evt_enable_out[pndcmd_pkg::EN_PLDM_BIT];
  wire want_spdm = spdm_event_in &&
    evt_enable_out[pndcmd_pkg::EN_SPDM_BIT];

  // picks one notification per cycle; medium first
  function automatic logic [7:0] pick_evt(input logic m, input logic p);
    if (m)
      pick_evt = pndcmd_pkg::EVT_MEDIUM;
    else if (p)
      pick_evt = pndcmd_pkg::EVT_PLDM;
    else
      pick_evt = pndcmd_pkg::EVT_SPDM;
  endfunction

  // next response fields
  logic [7:0] next_type;
  logic [15:0] next_code;
  logic [15:0] next_reason;
  logic next_has_msg;
  logic [7:0] next_flags;
  always_comb begin
    next_type = pndcmd_pkg::RSP_UNKNOWN;
    next_code = pndcmd_pkg::RESP_OK;
    next_reason = pndcmd_pkg::REASON_NONE;
    next_has_msg = 1'b0;
    next_flags = pndcmd_pkg::FLAGS_RESET;
    if (is_query) begin
      next_type = pndcmd_pkg::RSP_QUERY_PEND;
      // empty queue still succeeds with no message
      next_has_msg = !q_empty;
    end else if (is_reply) begin
      next_type = pndcmd_pkg::RSP_SEND_REPLY;
      next_flags[pndcmd_pkg::FLAG_PEND_BIT] = !q_empty;
    end else if (is_enable) begin
      next_type = pndcmd_pkg::RSP_EVT_ENABLE;
    end else if (is_other) begin
      // generic failure for errored or foreign commands
      next_type = cmd_type_in | 8'h80;
      next_code = pndcmd_pkg::RSP_FAIL;
      next_reason = pndcmd_pkg::REASON_UNKNOWN;
    end
  end

  // response registers, one-cycle strobe
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_type_out <= 8'h00;
      rsp_code_out <= pndcmd_pkg::RESP_OK;
      rsp_reason_out <= pndcmd_pkg::REASON_NONE;
      rsp_has_msg_out <= 1'b0;
      rsp_msg_out <= '0;
      rsp_flags_out <= pndcmd_pkg::FLAGS_RESET;
    end else begin
      rsp_valid_out <= cmd_valid_in;
      rsp_type_out <= next_type;
      rsp_code_out <= next_code;
      rsp_reason_out <= next_reason;
      rsp_has_msg_out <= next_has_msg;
      rsp_msg_out <= next_has_msg ? q_head : '0;
      rsp_flags_out <= next_flags;
    end
  end

  // enable bits and owner identifier
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_enable_out <= pndcmd_pkg::EN_RESET;
      evt_owner_out <= pndcmd_pkg::OWNER_ID_RESET;
    end else if (is_enable) begin
      evt_enable_out <= en_map[2:0];
      evt_owner_out <= cmd_owner_in;
    end
  end

  // notification strobe; owner id rides along on evt_owner_out
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_valid_out <= 1'b0;
      evt_type_out <= 8'h00;
    end else begin
      evt_valid_out <= want_medium || want_pldm || want_spdm;
      evt_type_out <= pick_evt(want_medium, want_pldm);
    end
  end

  // status: pending flag and last reply word from the controller
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pending_out <= 1'b0;
      req_full_out <= 1'b0;
      reply_word_out <= 32'h00000000;
    end else begin
      // reflects queue after this cycle's push and pop
      pending_out <= req_push_in || (q_pop ? more_after_pop : !q_empty);
      req_full_out <= q_full;
      if (is_reply)
        reply_word_out <= cmd_word16_in;
    end
  end
endmodule

// ### bench/pndcmd_properties.sv
// port checker for the command block
// assumes it is bound onto pndcmd_core
`timescale 1ns/10ps
module pndcmd_properties (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_type_in,
  input wire logic cmd_error_in,
  input wire logic [31:0] cmd_word16_in,
  input wire logic [7:0] cmd_owner_in,
  input wire logic rsp_valid_out,
  input wire logic [7:0] rsp_type_out,
  input wire logic [15:0] rsp_code_out,
  input wire logic [15:0] rsp_reason_out,
  input wire logic rsp_has_msg_out,
  input wire logic [7:0] rsp_flags_out,
  input wire logic evt_valid_out,
  input wire logic [7:0] evt_type_out,
  input wire logic [7:0] evt_owner_out,
  input wire logic [2:0] evt_enable_out,
  input wire logic pending_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // clean command strobe
  wire ok = cmd_valid_in && !cmd_error_in;
  // enables as seen one edge before a notification
  logic [2:0] en_q;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_q <= 3'h0;
    end else begin
      en_q <= evt_enable_out;
    end
  end
  property p_rsp;
    cmd_valid_in |=> rsp_valid_out;
  endproperty
  property p_qry;
    ok && cmd_type_in == 8'h56 |=> rsp_type_out == 8'hD6 && !rsp_code_out;
  endproperty
  property p_nomsg;
    ok && cmd_type_in == 8'h56 && !pending_out |=> !rsp_has_msg_out;
  endproperty
  property p_flg;
    rsp_valid_out |-> rsp_flags_out[7:1] == 7'h0;
  endproperty
  property p_more;
    ok && cmd_type_in == 8'h57 |=> rsp_type_out == 8'hD7
      && rsp_flags_out[0] == $past(pending_out);
  endproperty
  property p_en;
    ok && cmd_type_in == 8'h55 |=> rsp_type_out == 8'hD5
      && evt_enable_out == $past(cmd_word16_in[2:0])
      && evt_owner_out == $past(cmd_owner_in);
  endproperty
  property p_gate;
    evt_valid_out |-> en_q[evt_type_out[1:0]];
  endproperty
  property p_err;
    cmd_valid_in && cmd_error_in |=> rsp_reason_out == 16'h3;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no response");
  a_qry: assert property (p_qry) else $error("bad query");
  a_nomsg: assert property (p_nomsg) else $error("stray msg");
  a_flg: assert property (p_flg) else $error("flag bits");
  a_more: assert property (p_more) else $error("more flag");
  a_en: assert property (p_en) else $error("enable");
  a_gate: assert property (p_gate) else $error("gating");
  a_err: assert property (p_err) else $error("reason");
  c_reply: cover property (ok && cmd_type_in == 8'h57);
  c_evt: cover property (evt_valid_out);
  c_msg: cover property (rsp_has_msg_out);
endmodule
bind pndcmd_core pndcmd_properties chk_u (.mclk_in, .sys_rst_in,
  .cmd_valid_in, .cmd_type_in, .cmd_error_in, .cmd_word16_in,
  .cmd_owner_in, .rsp_valid_out, .rsp_type_out, .rsp_code_out,
  .rsp_reason_out, .rsp_has_msg_out, .rsp_flags_out, .evt_valid_out,
  .evt_type_out, .evt_owner_out, .evt_enable_out, .pending_out);

// ### bench/pndcmd_mc_model.sv
// management controller stand-in issuing decoded commands
// assumes the bench calls send, one command at a time
`timescale 1ns/10ps
module pndcmd_mc_model (
  input wire logic mclk_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_type_out,
  output logic cmd_error_out,
  output logic [31:0] cmd_word_out,
  output logic [7:0] cmd_owner_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_type_out = 8'h00;
    cmd_error_out = 1'b0;
    cmd_word_out = 32'h00000000;
    cmd_owner_out = 8'h00;
  end
  // one-cycle strobe; word and owner fields inverted after release
  task automatic send(input logic [7:0] t, input logic [31:0] w,
                      input logic [7:0] o, input logic e);
    @(posedge mclk_in);
    cmd_valid_out <= 1'b1;
    cmd_type_out <= t;
    cmd_word_out <= w;
    cmd_owner_out <= o;
    cmd_error_out <= e;
    @(posedge mclk_in);
    cmd_valid_out <= 1'b0;
    cmd_word_out <= ~w;
    cmd_owner_out <= ~o;
  endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the command block
// assumes the mc model and the bound checker
`timescale 1ns/10ps
module tb;
  logic mclk_in, sys_rst_in, req_push_in, medium_event_in, spdm_event_in;
  logic [31:0] req_data_in, rsp_msg_out, w, s = 32'hFC3BD513;
  logic cv, ce, rsp_valid_out, rsp_has_msg_out, evt_valid_out, pending_out;
  logic [7:0] ct, co, own, rsp_type_out, rsp_flags_out;
  logic [7:0] evt_type_out, evt_owner_out;
  logic [15:0] rsp_code_out, rsp_reason_out;
  logic [31:0] reply_word_out, rw;
  logic req_full_out;
  logic [2:0] en, evt_enable_out;
  logic [80:0] q[$];
  logic [15:0] eq[$];
  logic [31:0] sq[$];
  int error_cnt = 0, compares = 0;
  pndcmd_mc_model mc_u (.mclk_in, .cmd_valid_out(cv), .cmd_type_out(ct),
    .cmd_error_out(ce), .cmd_word_out(w), .cmd_owner_out(co));
  pndcmd_core dut_u (.mclk_in, .sys_rst_in, .cmd_valid_in(cv),
    .cmd_type_in(ct), .cmd_error_in(ce), .cmd_word16_in(w),
    .cmd_owner_in(co), .req_push_in, .req_data_in, .req_full_out,
    .medium_event_in, .spdm_event_in, .rsp_valid_out, .rsp_type_out,
    .rsp_code_out, .rsp_reason_out, .rsp_has_msg_out, .rsp_msg_out,
    .rsp_flags_out, .evt_valid_out, .evt_type_out, .evt_owner_out,
    .evt_enable_out, .pending_out, .reply_word_out);
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task cmp(input logic [80:0] e, input logic [80:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task results;
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // note the expected answer, then issue
  task cmd(input logic [7:0] t, input logic [31:0] d, input logic e,
           input logic [15:0] c, input logic h, input logic [31:0] m);
    q.push_back({t | 8'h80, c, ((c != 16'h0) ? 16'h0003 : 16'h0000),
      h, m, 7'h0, t == 8'h57 && sq.size() > 0});
    mc_u.send(t, d, own, e);
  endtask
  // queue one local request; first into empty raises 0x71 when enable bit 1 is set
  task push(input logic [31:0] d);
    if (sq.size() == 0 && en[1]) eq.push_back({8'h71, own});
    sq.push_back(d);
    @(posedge mclk_in);
    req_push_in <= 1'b1;
    req_data_in <= d;
    @(posedge mclk_in);
    req_push_in <= 1'b0;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk_in);
    error_cnt++;
    results;
  end
  // answers compared oldest note first
  always @(posedge mclk_in) begin
    if (rsp_valid_out === 1'b1)
      cmp(q.size() ? q.pop_front() : '1, {rsp_type_out, rsp_code_out,
        rsp_reason_out,
        rsp_has_msg_out, rsp_msg_out, rsp_flags_out});
    if (evt_valid_out === 1'b1)
      cmp(eq.size() ? eq.pop_front() : '1, {evt_type_out, evt_owner_out});
  end
  initial begin
    {sys_rst_in, req_push_in, medium_event_in, spdm_event_in} = 4'hF;
    {medium_event_in, spdm_event_in, req_push_in} = 3'h0;
    req_data_in = 32'h0;
    en = 3'h0;
    own = xs();
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    cmp(3'h0, evt_enable_out);
    cmd(8'h56, 32'h0, 1'b0, 16'h0, 1'b0, 32'h0);
    en = 3'h7;
    cmd(8'h55, {29'h0, en}, 1'b0, 16'h0, 1'b0, 32'h0);
    push(xs());
    push(xs());
    repeat (2) begin
      cmd(8'h56, 32'h0, 1'b0, 16'h0, 1'b1, sq.pop_front());
      rw = xs();
      cmd(8'h57, rw, 1'b0, 16'h0, 1'b0, 32'h0);
      @(negedge mclk_in);
      cmp(rw, reply_word_out);
    end
    @(posedge mclk_in);
    spdm_event_in <= 1'b1;
    eq.push_back({8'h72, own});
    @(posedge mclk_in);
    spdm_event_in <= 1'b0;
    en = 3'h0;
    cmd(8'h55, 32'h0, 1'b0, 16'h0, 1'b0, 32'h0);
    medium_event_in <= 1'b1;
    @(posedge mclk_in);
    medium_event_in <= 1'b0;
    push(xs());
    cmd(8'h56, 32'h0, 1'b1, 16'h1, 1'b0, 32'h0);
    cmd(8'h50, 32'h0, 1'b0, 16'h1, 1'b0, 32'h0);
    cmd(8'h56, 32'h0, 1'b0, 16'h0, 1'b1, sq.pop_front());
    // fill the queue to its depth, enables off so no notification
    repeat (4) push(xs());
    @(posedge mclk_in);
    @(negedge mclk_in);
    cmp(1'b1, req_full_out);
    cmp(1'b1, pending_out);
    repeat (4) @(posedge mclk_in);
    cmp(65'h0, q.size() + eq.size());
    results;
  end
endmodule
